// File: ccs_chan.sv
/*
 one channel: configuration register, cascade start, retries,
 output-enable drive style and servo/dac control.
 assumes the top hands in write strobes and channel-level events.
*/
`timescale 1ns/1ns
module ccs_chan
    import ccs_pkg::*;
#(
    parameter int RISE_CYC = CCS_RISE_CYC,
    parameter int RETRY_CYC = CCS_RETRY_CYC,
    parameter int MAX_RETRY = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // configuration access
    input wire logic cfg_wr,
    input wire logic [15:0] cfg_wdata,
    output logic [15:0] cfg_rdata,
    // control and events
    input wire logic [3:0] ctl_in,
    input wire logic op_on,
    input wire logic fault,
    input wire logic fault_line_zero,
    input wire logic fault_line_zero_response_enable,
    input wire logic warn_out,
    input wire logic target_reached,
    input wire logic soft_done,
    // results
    output ccs_state_e state,
    output ccs_en_e en_drive,
    output ccs_ana_s ana,
    output logic fl0_event
);
    logic [15:0] cfg_ff;
    ccs_cfg_s cfg;
    ccs_state_e state_ff;
    logic [31:0] cnt_ff;
    logic [7:0] retry_ff;
    logic fault_off_ff;
    logic servo_done_ff;
    logic ctl_sel_in;
    logic start_ok;

    // reserved bits never stored
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_ff <= CCS_CFG_RST;
        end else if (cfg_wr) begin
            cfg_ff <= cfg_wdata & CCS_CFG_MASK;
        end
    end
    assign cfg_rdata = cfg_ff & CCS_CFG_MASK;

    // field decode
    always_comb begin
        cfg.cascade = cfg_ff[CCS_B_CASCADE];
        cfg.ctl_sel = cfg_ff[CCS_B_SEL_HI:CCS_B_SEL_LO];
        cfg.fast_servo_en = ~cfg_ff[CCS_B_FAST_SERVO_OFF];
        cfg.sup_step_mv = cfg_ff[CCS_B_SUP_RES] ? CCS_STEP_LO_RES
                                                : CCS_STEP_HI_RES;
        cfg.servo_cont = cfg_ff[CCS_B_SERVO_CONT];
        cfg.servo_warn = cfg_ff[CCS_B_SERVO_WARN];
        cfg.dac_mode = ccs_dac_e'(cfg_ff[CCS_B_DAC_HI:CCS_B_DAC_LO]);
        cfg.weak_pu = cfg_ff[CCS_B_WPU];
        cfg.weak_pd = cfg_ff[CCS_B_WPD];
        cfg.gain_hi = cfg_ff[CCS_B_GAIN];
        cfg.pol_noninv = cfg_ff[CCS_B_POL];
    end

    // selected control input
    assign ctl_sel_in = ctl_in[cfg.ctl_sel];
    // cascade slave waits for previous supply power good
    assign start_ok = op_on && ctl_sel_in;

    // channel sequence
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= CCS_ST_OFF;
            cnt_ff <= 32'h0000_0000;
            retry_ff <= 8'h00;
            fault_off_ff <= 1'b0;
        end else begin
            unique case (state_ff)
                CCS_ST_OFF: begin
                    if (op_on) begin
                        state_ff <= CCS_ST_WAIT;
                    end
                end
                CCS_ST_WAIT: begin
                    if (!op_on) begin
                        state_ff <= CCS_ST_OFF;
                    end else if (start_ok) begin
                        state_ff <= CCS_ST_RISE;
                        cnt_ff <= 32'h0000_0000;
                    end
                end
                CCS_ST_RISE, CCS_ST_ON: begin
                    if (fault || (fault_line_zero
                            && fault_line_zero_response_enable)) begin
                        state_ff <= CCS_ST_FAULT;
                        fault_off_ff <= 1'b1;
                        cnt_ff <= 32'h0000_0000;
                    end else if (!op_on || (!cfg.cascade && !ctl_sel_in)) begin
                        state_ff <= CCS_ST_OFF;
                        fault_off_ff <= 1'b0;
                    end else if (state_ff == CCS_ST_RISE) begin
                        if (cnt_ff == 32'(RISE_CYC - 1)) begin
                            state_ff <= CCS_ST_ON;
                            retry_ff <= 8'h00;
                        end else begin
                            cnt_ff <= cnt_ff + 32'h0000_0001;
                        end
                    end
                end
                CCS_ST_FAULT: begin
                    if (!op_on) begin
                        state_ff <= CCS_ST_OFF;
                    end else if (cnt_ff == 32'(RETRY_CYC - 1)) begin
                        cnt_ff <= 32'h0000_0000;
                        if (retry_ff < 8'(MAX_RETRY)) begin
                            retry_ff <= retry_ff + 8'h01;
                            // cascade slave retries even with input low
                            if (cfg.cascade || ctl_sel_in) begin
                                state_ff <= CCS_ST_RISE;
                            end
                        end else begin
                            state_ff <= CCS_ST_LATCH;
                        end
                    end else begin
                        cnt_ff <= cnt_ff + 32'h0000_0001;
                    end
                end
                CCS_ST_LATCH: begin
                    // off-then-on command clears faulted-off state
                    if (!op_on) begin
                        state_ff <= CCS_ST_OFF;
                        retry_ff <= 8'h00;
                    end
                end
                default: begin
                    state_ff <= CCS_ST_OFF;
                end
            endcase
        end
    end
    assign state = state_ff;

    // output-enable pin drive style
    always_comb begin
        if (state_ff == CCS_ST_RISE || state_ff == CCS_ST_ON) begin
            en_drive = cfg.weak_pu ? CCS_EN_WEAK_UP : CCS_EN_HIZ;
        end else if (cfg.weak_pd && !fault_off_ff) begin
            en_drive = CCS_EN_WEAK_DN;
        end else begin
            en_drive = CCS_EN_FAST_DN;
        end
    end

    // servo bookkeeping once initial target reached
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            servo_done_ff <= 1'b0;
        end else if (state_ff != CCS_ST_ON) begin
            servo_done_ff <= 1'b0;
        end else if (cfg.servo_warn && warn_out) begin
            servo_done_ff <= 1'b0;
        end else if (target_reached) begin
            servo_done_ff <= 1'b1;
        end
    end

    // dac and servo controls after rise time
    always_comb begin
        ana.servo_run = 1'b0;
        ana.dac_connect = 1'b0;
        ana.dac_soft = 1'b0;
        if (state_ff == CCS_ST_ON) begin
            unique case (cfg.dac_mode)
                CCS_DAC_SERVO: begin
                    ana.dac_connect = soft_done;
                    ana.dac_soft = 1'b1;
                    ana.servo_run = cfg.servo_cont || !servo_done_ff;
                end
                CCS_DAC_OPEN: begin
                    ana.dac_connect = 1'b0;
                end
                CCS_DAC_DIRECT: begin
                    ana.dac_connect = 1'b1;
                end
                CCS_DAC_SOFT: begin
                    ana.dac_connect = soft_done;
                    ana.dac_soft = 1'b1;
                end
            endcase
        end
        ana.fast_servo = cfg.fast_servo_en;
        ana.gain_hi = cfg.gain_hi;
        ana.pol_noninv = cfg.pol_noninv;
        ana.sup_step_mv = cfg.sup_step_mv;
    end

    // broadcast shutdown seen by this channel
    assign fl0_event = fault_line_zero && fault_line_zero_response_enable
        && (state_ff == CCS_ST_RISE || state_ff == CCS_ST_ON);
endmodule // ccs_chan

// File: ccs_conv_model.sv
/*
 four dc/dc converters: power good follows the enable pin.
 assumes a released or pulled-up enable pin means converter on.
*/
`timescale 1ns/1ns
module ccs_conv_model
    import ccs_pkg::*;
#(
    parameter int PG_DLY = 3
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // enable pins in, power good out
    input wire ccs_en_e [3:0] en_drive,
    output logic [3:0] pg
);
    logic [3:0] cnt_ff [4];
    // count up while enabled, clear when pulled down
    always_ff @(posedge clk or posedge sys_rst) begin
        for (int i = 0; i < 4; i++) begin
            if (sys_rst || en_drive[i] inside {CCS_EN_WEAK_DN,
                CCS_EN_FAST_DN}) begin
                cnt_ff[i] <= 4'h0;
            end else if (cnt_ff[i] != 4'(PG_DLY)) begin
                cnt_ff[i] <= cnt_ff[i] + 4'h1;
            end
        end
    end
    // each converter's own power good, chained by the bench
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pg[i] = (cnt_ff[i] == 4'(PG_DLY));
        end
    end
endmodule // ccs_conv_model

// File: ccs_pkg.sv
/*
 package for the per-channel configuration and cascade sequencer:
 field positions, reset values, encodings and carrier structs.
 assumes a single 10 MHz clock domain.
*/
package ccs_pkg;
    localparam int CCS_NCHAN = 4;
    localparam int CCS_CFG_W = 16;
    // field positions
    localparam int CCS_B_CASCADE = 14;
    localparam int CCS_B_SEL_HI = 13;
    localparam int CCS_B_SEL_LO = 12;
    localparam int CCS_B_FAST_SERVO_OFF = 11;
    localparam int CCS_B_SUP_RES = 10;
    localparam int CCS_B_SERVO_CONT = 7;
    localparam int CCS_B_SERVO_WARN = 6;
    localparam int CCS_B_DAC_HI = 5;
    localparam int CCS_B_DAC_LO = 4;
    localparam int CCS_B_WPU = 3;
    localparam int CCS_B_WPD = 2;
    localparam int CCS_B_GAIN = 1;
    localparam int CCS_B_POL = 0;
    // writable bits: 15, 9 and 8 are reserved
    localparam logic [15:0] CCS_CFG_MASK = 16'h7cff;
    localparam logic [15:0] CCS_CFG_RST = 16'h0000;
    // supervisor step in mV
    localparam logic [3:0] CCS_STEP_HI_RES = 4'h4;
    localparam logic [3:0] CCS_STEP_LO_RES = 4'h8;
    // rise time after turn-on, 1 ms at 100 ns
    localparam int CCS_RISE_NS = 1000000;
    localparam int CCS_CLK_NS = 100;
    localparam int CCS_RISE_CYC = (CCS_RISE_NS + CCS_CLK_NS - 1) / CCS_CLK_NS;
    localparam int CCS_RETRY_NS = 100000;
    localparam int CCS_RETRY_CYC = (CCS_RETRY_NS + CCS_CLK_NS - 1) / CCS_CLK_NS;

    typedef enum logic [1:0] {
        CCS_DAC_SERVO = 2'h0,
        CCS_DAC_OPEN = 2'h1,
        CCS_DAC_DIRECT = 2'h2,
        CCS_DAC_SOFT = 2'h3
    } ccs_dac_e;

    // output-enable pin drive style
    typedef enum logic [1:0] {
        CCS_EN_HIZ = 2'h0,
        CCS_EN_WEAK_UP = 2'h1,
        CCS_EN_WEAK_DN = 2'h2,
        CCS_EN_FAST_DN = 2'h3
    } ccs_en_e;

    // channel state along the usual path is gray coded
    typedef enum logic [2:0] {
        CCS_ST_OFF = 3'h0,
        CCS_ST_WAIT = 3'h1,
        CCS_ST_RISE = 3'h3,
        CCS_ST_ON = 3'h2,
        CCS_ST_FAULT = 3'h6,
        CCS_ST_LATCH = 3'h7
    } ccs_state_e;

    // decoded configuration of one channel
    typedef struct packed {
        logic cascade;
        logic [1:0] ctl_sel;
        logic fast_servo_en;
        logic [3:0] sup_step_mv;
        logic servo_cont;
        logic servo_warn;
        ccs_dac_e dac_mode;
        logic weak_pu;
        logic weak_pd;
        logic gain_hi;
        logic pol_noninv;
    } ccs_cfg_s;

    // servo and dac controls of one channel
    typedef struct packed {
        logic servo_run;
        logic dac_connect;
        logic dac_soft;
        logic fast_servo;
        logic gain_hi;
        logic pol_noninv;
        logic [3:0] sup_step_mv;
    } ccs_ana_s;
endpackage

// File: ccs_top.sv
/*
 four-channel configuration and cascade sequence-on block.
 assumes register writes arrive already decoded by the serial bus
 front end, one channel per page, and all inputs synchronous to clk.
*/
// Function
// - reserved bits 15, 9, 8 always read zero
// - bit 14 makes the selected control input a cascade start input
// - bits 13:12 select which control input governs the channel
// - bit 11 set disables fast servo
// - bit 10 picks 4mV or 8mV supervisor step
// - bit 7 keeps servoing after target in dac mode 00
// - bit 6 re-servos on voltage warning in mode 00, no continuous servo
// - bits 5:4 choose dac connection once on and rise time elapsed
// - bit 3 gives weak pull-up when on, else three-state
// - bit 2 picks weak pull-down for soft stop, fast for fault
// - bit 1 selects dac buffer gain
// - bit 0 selects dac output polarity
// - cascade slave starts only once its selected input is high
// - cascade slave does fault retries with control input low
// - off-then-on command clears latched faulted-off state
// - broadcast shutdown raises alert and per-channel event flag
`timescale 1ns/1ns
module ccs_top
    import ccs_pkg::*;
#(
    parameter int NCHAN = CCS_NCHAN,
    parameter int RISE_CYC = CCS_RISE_CYC,
    parameter int RETRY_CYC = CCS_RETRY_CYC,
    parameter int MAX_RETRY = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // configuration register access
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [1:0] cfg_page,
    input wire logic [15:0] cfg_wdata,
    output logic [15:0] cfg_rdata,
    // control inputs from converter power-good outputs
    input wire logic [3:0] ctl_in,
    // operation command, per channel on request
    input wire logic [NCHAN-1:0] op_on,
    // fault and monitor events
    input wire logic [NCHAN-1:0] fault,
    input wire logic fault_line_zero,
    input wire logic [NCHAN-1:0] fault_line_zero_response_enable,
    input wire logic [NCHAN-1:0] warn_out,
    input wire logic [NCHAN-1:0] target_reached,
    input wire logic [NCHAN-1:0] soft_done,
    input wire logic [NCHAN-1:0] event_clr,
    // channel state
    output logic [NCHAN-1:0] chan_on,
    output ccs_en_e [NCHAN-1:0] en_drive,
    output ccs_ana_s [NCHAN-1:0] ana,
    // status and alert
    output logic [NCHAN-1:0] fault_line_zero_input_event,
    output logic alert_output_n
);
    logic [15:0] rd_w [NCHAN];
    ccs_state_e st_w [NCHAN];
    ccs_en_e en_w [NCHAN];
    ccs_ana_s ana_w [NCHAN];
    logic [NCHAN-1:0] ev_w;
    logic [NCHAN-1:0] ev_ff;
    logic [NCHAN-1:0] on_ff;
    ccs_en_e [NCHAN-1:0] en_ff;
    ccs_ana_s [NCHAN-1:0] ana_ff;
    logic [15:0] rdata_ff;
    logic alert_n_ff;

    // one configuration register per channel
    genvar g;
    generate
        for (g = 0; g < NCHAN; g++) begin : g_ch
            ccs_chan #(
                .RISE_CYC(RISE_CYC),
                .RETRY_CYC(RETRY_CYC),
                .MAX_RETRY(MAX_RETRY)
            ) ccs_chan_i (
                .clk(clk),
                .sys_rst(sys_rst),
                .cfg_wr(cfg_wr && (cfg_page == 2'(g))),
                .cfg_wdata(cfg_wdata),
                .cfg_rdata(rd_w[g]),
                .ctl_in(ctl_in),
                .op_on(op_on[g]),
                .fault(fault[g]),
                .fault_line_zero(fault_line_zero),
                .fault_line_zero_response_enable(
                    fault_line_zero_response_enable[g]),
                .warn_out(warn_out[g]),
                .target_reached(target_reached[g]),
                .soft_done(soft_done[g]),
                .state(st_w[g]),
                .en_drive(en_w[g]),
                .ana(ana_w[g]),
                .fl0_event(ev_w[g])
            );
        end
    endgenerate

    // register read data
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_ff <= CCS_CFG_RST;
        end else if (cfg_rd) begin
            rdata_ff <= rd_w[cfg_page];
        end
    end
    assign cfg_rdata = rdata_ff;

    // channel outputs registered
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            on_ff <= '0;
            // per element, so the enum type is kept
            for (int i = 0; i < NCHAN; i++) begin
                en_ff[i] <= CCS_EN_FAST_DN;
            end
            ana_ff <= '0;
        end else begin
            for (int i = 0; i < NCHAN; i++) begin
                on_ff[i] <= (st_w[i] == CCS_ST_ON);
                en_ff[i] <= en_w[i];
                ana_ff[i] <= ana_w[i];
            end
        end
    end
    assign chan_on = on_ff;
    assign en_drive = en_ff;
    assign ana = ana_ff;

    // sticky fault-line events, set wins over clear
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ev_ff <= '0;
        end else begin
            ev_ff <= (ev_ff & ~event_clr) | ev_w;
        end
    end
    assign fault_line_zero_input_event = ev_ff;

    // alert low while any event is pending
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            alert_n_ff <= 1'b1;
        end else begin
            alert_n_ff <= ~(|((ev_ff & ~event_clr) | ev_w));
        end
    end
    assign alert_output_n = alert_n_ff;
endmodule // ccs_top

// File: ccs_top_assertions.sv
/*
 checker for ccs_top: read-back, drive styles and events.
 assumes it is bound into ccs_top and sees only its ports.
*/
`timescale 1ns/1ns
module ccs_chk
    import ccs_pkg::*;
#(
    parameter int NCHAN = CCS_NCHAN
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register access
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [1:0] cfg_page,
    input wire logic [15:0] cfg_wdata,
    input wire logic [15:0] cfg_rdata,
    // channel inputs
    input wire logic [3:0] ctl_in,
    input wire logic [NCHAN-1:0] op_on,
    input wire logic [NCHAN-1:0] fault,
    input wire logic fault_line_zero,
    input wire logic [NCHAN-1:0] fault_line_zero_response_enable,
    // channel outputs
    input wire logic [NCHAN-1:0] chan_on,
    input wire ccs_en_e [NCHAN-1:0] en_drive,
    input wire ccs_ana_s [NCHAN-1:0] ana,
    input wire logic [NCHAN-1:0] fault_line_zero_input_event,
    input wire logic alert_output_n
);
    import ccs_pkg::*;
    logic [15:0] shd_ff [4];
    // shadow of what each page should hold
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            shd_ff <= '{default: 16'h0000};
        end else if (cfg_wr) begin
            shd_ff[cfg_page] <= cfg_wdata & 16'h7cff;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    rsv_zero_a: assert property (
        cfg_rdata[15] == 1'b0 && cfg_rdata[9:8] == 2'h0)
        else $error("reserved bits read nonzero");
    rd_back_a: assert property (
        cfg_rd && !cfg_wr |=> cfg_rdata == $past(shd_ff[cfg_page]))
        else $error("read data differs from written page");
    sel_gate_a: assert property (
        $rose(chan_on[0]) && !shd_ff[0][14]
        |-> $past(ctl_in[shd_ff[0][13:12]]))
        else $error("channel started with selected input low");
    cas_start_a: assert property (
        $rose(chan_on[1]) |-> $past(op_on[1]))
        else $error("slave started without on request");
    on_style_a: assert property (
        $rose(chan_on[0]) |-> ##[0:1] en_drive[0] ==
        (shd_ff[0][3] ? CCS_EN_WEAK_UP : CCS_EN_HIZ))
        else $error("wrong enable style while on");
    fault_dn_a: assert property (
        chan_on[1] && fault[1] |-> ##[1:3] en_drive[1] == CCS_EN_FAST_DN)
        else $error("fault did not give fast pull-down");
    soft_dn_a: assert property (
        $fell(op_on[1]) && chan_on[1] && shd_ff[1][2] && !fault[1]
        && !fault_line_zero |-> ##[1:3] en_drive[1] == CCS_EN_WEAK_DN)
        else $error("soft stop did not give weak pull-down");
    fl_evt_a: assert property (
        fault_line_zero && fault_line_zero_response_enable[1] && chan_on[1]
        |=> fault_line_zero_input_event[1])
        else $error("fault line event not flagged");
    alert_evt_a: assert property (
        alert_output_n == !(|fault_line_zero_input_event))
        else $error("alert does not follow pending events");
    dac_open_a: assert property (
        chan_on[1] && shd_ff[1][5:4] == 2'h1 |-> !ana[1].dac_connect)
        else $error("dac connected in open mode");
    ana_cfg_a: assert property (
        $rose(chan_on[0]) |-> ##[0:1] ana[0].gain_hi == shd_ff[0][1]
        && ana[0].pol_noninv == shd_ff[0][0] && ana[0].sup_step_mv ==
        (shd_ff[0][10] ? CCS_STEP_LO_RES : CCS_STEP_HI_RES))
        else $error("analog controls differ from config");
endmodule // ccs_chk

bind ccs_top ccs_chk #(.NCHAN(NCHAN)) ccs_chk_i (
    .clk(clk), .sys_rst(sys_rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_page(cfg_page), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .ctl_in(ctl_in), .op_on(op_on), .fault(fault),
    .fault_line_zero(fault_line_zero),
    .fault_line_zero_response_enable(fault_line_zero_response_enable),
    .chan_on(chan_on), .en_drive(en_drive), .ana(ana),
    .fault_line_zero_input_event(fault_line_zero_input_event),
    .alert_output_n(alert_output_n));

// File: ccs_top_tb.sv
/*
 testbench for ccs_top with a chain of converter models.
 assumes rise and retry counts of four cycles.
*/
`timescale 1ns/1ns
module ccs_top_tb;
    import ccs_pkg::*;
    logic clk, sys_rst, cfg_wr, cfg_rd, ctl0, fl0, alert_n;
    logic [1:0] cfg_page;
    logic [15:0] cfg_wdata, cfg_rdata;
    logic [3:0] op_on, flt, fl0_en, warn, tgt, sdone, eclr, chan_on, evt, pg;
    ccs_en_e [3:0] en_drive;
    ccs_ana_s [3:0] ana;
    int n_mismatch = 0, n_tests = 0, cyc = 0;
    ccs_top #(.RISE_CYC(4), .RETRY_CYC(4)) ccs_top_i (
        .clk(clk), .sys_rst(sys_rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_page(cfg_page), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .ctl_in({pg[2:0], ctl0}), .op_on(op_on), .fault(flt),
        .fault_line_zero(fl0), .fault_line_zero_response_enable(fl0_en),
        .warn_out(warn), .target_reached(tgt), .soft_done(sdone),
        .event_clr(eclr), .chan_on(chan_on), .en_drive(en_drive),
        .ana(ana), .fault_line_zero_input_event(evt),
        .alert_output_n(alert_n));
    ccs_conv_model ccs_conv_model_i (.clk(clk), .sys_rst(sys_rst),
        .en_drive(en_drive), .pg(pg));
    // clock
    initial begin
        clk = 0;
        forever #50 clk = ~clk;
    end
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("mismatches %0d checks %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask
    task automatic wr1(input logic [1:0] p, input logic [15:0] d);
        cfg_wr = 1;
        cfg_page = p;
        cfg_wdata = d;
        tick(1);
        cfg_wr = 0;
        tick(1);
    endtask
    task automatic rd(input logic [1:0] p, input logic [15:0] exp);
        cfg_rd = 1;
        cfg_page = p;
        tick(1);
        cfg_rd = 0;
        cmp(cfg_rdata, exp);
        tick(1);
    endtask
    task automatic wait_on(input logic [3:0] m);
        for (int k = 0; k < 60 && (chan_on & m) !== m; k++) tick(1);
    endtask
    task automatic t_regs();
        cfg_wr = 1;
        for (int p = 0; p < 4; p++) begin
            cfg_page = 2'(p);
            cfg_wdata = 16'h8300 | 16'(16'h1111 * p);
            tick(1);
        end
        cfg_wr = 0;
        tick(1);
        for (int p = 0; p < 4; p++) begin
            rd(2'(p), (16'h8300 | 16'(16'h1111 * p)) & 16'h7cff);
        end
    endtask
    task automatic t_cascade();
        wr1(0, 16'h000b);
        for (int i = 1; i < 4; i++) wr1(2'(i), 16'h4414 | 16'(i << 12));
        fl0_en = 4'he;
        op_on = 4'hf;
        tick(10);
        cmp(chan_on, 4'h0);
        ctl0 = 1;
        wait_on(4'h1);
        cmp(chan_on[1], 1'b0);
        wait_on(4'hf);
        cmp(chan_on, 4'hf);
        cmp(en_drive[0], CCS_EN_WEAK_UP);
        cmp(en_drive[1], CCS_EN_HIZ);
        cmp({ana[0].gain_hi, ana[0].pol_noninv}, 2'h3);
        cmp(ana[0].sup_step_mv, 4'h4);
        cmp(ana[1].sup_step_mv, 4'h8);
        cmp(ana[1].dac_connect, 1'b0);
        cmp(ana[1].fast_servo, 1'b1);
    endtask
    task automatic t_servo();
        wr1(0, 16'h008b);
        tgt[0] = 1;
        tick(4);
        cmp(ana[0].servo_run, 1'b1);
        wr1(0, 16'h000b);
        tick(3);
        cmp(ana[0].servo_run, 1'b0);
        wr1(0, 16'h004b);
        cmp(ana[0].servo_run, 1'b0);
        tgt[0] = 0;
        warn[0] = 1;
        tick(2);
        cmp(ana[0].servo_run, 1'b1);
        warn[0] = 0;
        wr1(0, 16'h000b);
    endtask
    task automatic t_retry();
        ctl0 = 0;
        tick(15);
        cmp(chan_on[1:0], 2'h2);
        flt[1] = 1;
        tick(1);
        flt[1] = 0;
        tick(2);
        cmp(en_drive[1], CCS_EN_FAST_DN);
        wait_on(4'h2);
        cmp(chan_on[1], 1'b1);
        flt[1] = 1;
        tick(12);
        flt[1] = 0;
        tick(8);
        cmp(chan_on[1], 1'b0);
        op_on[1] = 0;
        tick(2);
        op_on[1] = 1;
        ctl0 = 1;
        wait_on(4'hf);
        cmp(chan_on, 4'hf);
    endtask
    task automatic t_soft();
        op_on = 4'hc;
        tick(3);
        cmp(en_drive[0], CCS_EN_FAST_DN);
        cmp(en_drive[1], CCS_EN_WEAK_DN);
        op_on = 4'hf;
        wait_on(4'hf);
    endtask
    task automatic t_dac();
        wr1(2, 16'h6c24);
        cmp(ana[2].dac_connect, 1'b1);
        cmp(ana[2].fast_servo, 1'b0);
        wr1(2, 16'h6434);
        cmp({ana[2].dac_connect, ana[2].dac_soft}, 2'h1);
        sdone[2] = 1;
        tick(2);
        cmp(ana[2].dac_connect, 1'b1);
        sdone[2] = 0;
    endtask
    task automatic t_fl0();
        fl0 = 1;
        tick(1);
        fl0 = 0;
        tick(2);
        cmp(evt, 4'he);
        cmp(alert_n, 1'b0);
        eclr = 4'hf;
        tick(1);
        eclr = 0;
        tick(1);
        cmp(alert_n, 1'b1);
    endtask
    // reset, then the scenarios in turn
    initial begin
        {sys_rst, cfg_wr, cfg_rd, ctl0, fl0} = 5'h10;
        {cfg_page, cfg_wdata, op_on, flt, fl0_en} = '0;
        {warn, tgt, sdone, eclr} = '0;
        repeat (8) @(posedge clk);
        #10;
        sys_rst = 0;
        tick(1);
        cmp(en_drive, 8'hff);
        cmp({chan_on, alert_n}, 5'h01);
        rd(0, 16'h0000);
        t_regs();
        t_cascade();
        t_servo();
        t_retry();
        t_soft();
        t_dac();
        t_fl0();
        wrap_up();
    end
endmodule // ccs_top_tb
